// file: rtl/pgc_regs.sv
// Register file of the counter array: counter bytes, snapshot, channels.

// Overview of operation
// - Counter high byte is read/write at 0xFA, resets to zero.
// - High-byte reads return a snapshot taken only on low-byte reads.
// - Capture low bytes of modules 0,1,2 sit at 0xFB, 0xE9, 0xEB.
// - Select set: low-byte address reaches the reload low byte.
// - A write to a module low byte clears its comparator enable.
// - Capture high bytes of modules 0,1,2 sit at 0xFC, 0xEA, 0xEC.
// - Select set: high-byte address reaches the reload high byte.
// - A write to a module high byte sets its comparator enable.
// - Comparator enable is mode bit 6; one enables the comparator.
// - Counter low byte sits at 0xF9; reading it triggers the snapshot.
module pgc_regs (
    // Clock and reset.
    input  wire logic                 ref_clk_i,
    input  wire logic                 reset_i,
    // Special-function-register bus.
    input  wire pgc_pkg::pgc_sfr_req_s sfr_req_i,
    output pgc_pkg::pgc_sfr_rsp_s     sfr_rsp_o,
    // Counting datapath.
    input  wire logic                 count_tick_i,
    input  wire logic [2:0]           capture_strobe_i,
    // Register contents toward the datapath.
    output logic      [15:0]          counter_o,
    output logic      [2:0][15:0]     capture_value_o,
    output logic      [2:0][15:0]     auto_reload_o,
    output logic      [2:0][7:0]      module_mode_o,
    output logic      [2:0]           comparator_enable_o,
    output logic                      auto_reload_select_o
);
    import pgc_pkg::*;

    logic [7:0] snapshot;
    logic [7:0] pwm_config_register;
    logic [2:0] wr_low;
    logic [2:0] wr_high;
    logic [2:0] wr_mode;
    logic       rd_counter_low;
    logic       wr_counter_low;
    logic       wr_counter_high;
    logic [7:0] next_rdata;

    assign rd_counter_low  = sfr_req_i.rd
                             && sfr_req_i.addr == COUNTER_LOW_ADDR;
    assign wr_counter_low  = sfr_req_i.wr
                             && sfr_req_i.addr == COUNTER_LOW_ADDR;
    assign wr_counter_high = sfr_req_i.wr
                             && sfr_req_i.addr == COUNTER_HIGH_ADDR;
    assign auto_reload_select_o = pwm_config_register[AUTO_RELOAD_SEL_BIT];

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            assign wr_low[ch]  = sfr_req_i.wr
                                 && sfr_req_i.addr == CAP_LOW_ADDR[ch];
            assign wr_high[ch] = sfr_req_i.wr
                                 && sfr_req_i.addr == CAP_HIGH_ADDR[ch];
            assign wr_mode[ch] = sfr_req_i.wr
                                 && sfr_req_i.addr == MODE_ADDR[ch];
            assign comparator_enable_o[ch] =
                module_mode_o[ch][COMP_ENABLE_BIT];
            pgc_channel u_channel (
                .ref_clk_i            (ref_clk_i),
                .reset_i              (reset_i),
                .wdata_i              (sfr_req_i.wdata),
                .wr_low_i             (wr_low[ch]),
                .wr_high_i            (wr_high[ch]),
                .wr_mode_i            (wr_mode[ch]),
                .auto_reload_select_i (auto_reload_select_o),
                .capture_strobe_i     (capture_strobe_i[ch]),
                .counter_i            (counter_o),
                .capture_o            (capture_value_o[ch]),
                .reload_o             (auto_reload_o[ch]),
                .mode_o               (module_mode_o[ch])
            );
        end
    endgenerate

    // Software writes take priority over the counting tick.
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            counter_o <= WORD_RESET;
        end else if (wr_counter_low) begin
            counter_o[7:0] <= sfr_req_i.wdata;
        end else if (wr_counter_high) begin
            counter_o[15:8] <= sfr_req_i.wdata;
        end else if (count_tick_i) begin
            counter_o <= counter_o + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            snapshot <= BYTE_RESET;
        end else if (rd_counter_low) begin
            snapshot <= counter_o[15:8];
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pwm_config_register <= BYTE_RESET;
        end else if (sfr_req_i.wr && sfr_req_i.addr == PWM_CONFIG_ADDR) begin
            pwm_config_register <= sfr_req_i.wdata;
        end
    end

    // Read multiplexer; unmapped addresses read as zero.
    always_comb begin
        next_rdata = BYTE_RESET;
        if (sfr_req_i.addr == COUNTER_LOW_ADDR) begin
            next_rdata = counter_o[7:0];
        end else if (sfr_req_i.addr == COUNTER_HIGH_ADDR) begin
            next_rdata = snapshot;
        end else if (sfr_req_i.addr == PWM_CONFIG_ADDR) begin
            next_rdata = pwm_config_register;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (sfr_req_i.addr == CAP_LOW_ADDR[i]) begin
                    next_rdata = auto_reload_select_o
                        ? auto_reload_o[i][7:0]
                        : capture_value_o[i][7:0];
                end else if (sfr_req_i.addr == CAP_HIGH_ADDR[i]) begin
                    next_rdata = auto_reload_select_o
                        ? auto_reload_o[i][15:8]
                        : capture_value_o[i][15:8];
                end else if (sfr_req_i.addr == MODE_ADDR[i]) begin
                    next_rdata = module_mode_o[i];
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sfr_rsp_o <= '0;
        end else begin
            sfr_rsp_o.rvalid <= sfr_req_i.rd;
            sfr_rsp_o.rdata  <= sfr_req_i.rd ? next_rdata : BYTE_RESET;
        end
    end

    // Checks next to the logic above.
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    logic wr_c0_low;
    logic wr_c0_high;
    assign wr_c0_low  = sfr_req_i.wr && sfr_req_i.addr == CAP_LOW_ADDR[0];
    assign wr_c0_high = sfr_req_i.wr && sfr_req_i.addr == CAP_HIGH_ADDR[0];

    sequence s_low_read;
        rd_counter_low;
    endsequence

    sequence s_high_read;
        sfr_req_i.rd && sfr_req_i.addr == COUNTER_HIGH_ADDR;
    endsequence

    property p_snap_load;
        s_low_read |=> snapshot == $past(counter_o[15:8]);
    endproperty
    a_snap_load: assert property (p_snap_load)
        else $error("Snapshot not loaded on low-byte read.");

    property p_snap_hold;
        !rd_counter_low |=> $stable(snapshot);
    endproperty
    a_snap_hold: assert property (p_snap_hold)
        else $error("Snapshot changed without a low-byte read.");

    property p_low_then_high;
        s_low_read ##1 s_high_read |=>
            sfr_rsp_o.rdata == $past(counter_o[15:8], 2);
    endproperty
    a_low_then_high: assert property (p_low_then_high)
        else $error("High-byte read did not return the snapshot.");

    property p_low_read_data;
        s_low_read |=> sfr_rsp_o.rvalid
                       && sfr_rsp_o.rdata == $past(counter_o[7:0]);
    endproperty
    a_low_read_data: assert property (p_low_read_data)
        else $error("Counter low-byte read returned wrong data.");

    property p_high_write;
        wr_counter_high |=> counter_o[15:8] == $past(sfr_req_i.wdata);
    endproperty
    a_high_write: assert property (p_high_write)
        else $error("Counter high-byte write not stored.");

    property p_low_clears_enable;
        wr_c0_low |=> !comparator_enable_o[0]
            && module_mode_o[0] == ($past(module_mode_o[0])
                                    & ~(8'h01 << COMP_ENABLE_BIT));
    endproperty
    a_low_clears_enable: assert property (p_low_clears_enable)
        else $error("Low-byte write did not clear comparator enable.");

    property p_high_sets_enable;
        wr_c0_high |=> comparator_enable_o[0]
            && module_mode_o[0] == ($past(module_mode_o[0])
                                    | (8'h01 << COMP_ENABLE_BIT));
    endproperty
    a_high_sets_enable: assert property (p_high_sets_enable)
        else $error("High-byte write did not set comparator enable.");

    property p_reload_route;
        wr_c0_low && auto_reload_select_o |=>
            auto_reload_o[0][7:0] == $past(sfr_req_i.wdata)
            && capture_value_o[0] == ($past(capture_strobe_i[0])
                                      ? $past(counter_o)
                                      : $past(capture_value_o[0]));
    endproperty
    a_reload_route: assert property (p_reload_route)
        else $error("Low-byte write with select set missed the reload value.");

    property p_capture_route;
        sfr_req_i.wr && sfr_req_i.addr == CAP_HIGH_ADDR[1]
            && !auto_reload_select_o |=>
            capture_value_o[1][15:8] == $past(sfr_req_i.wdata)
            && $stable(auto_reload_o[1]);
    endproperty
    a_capture_route: assert property (p_capture_route)
        else $error("High-byte write with select clear missed the capture.");

endmodule

// file: rtl/pgc_pkg.sv
// Package with the register map, field positions and bus carrier types.
package pgc_pkg;

    localparam int          NUM_CH          = 3;
    localparam logic [7:0]  COUNTER_LOW_ADDR  = 8'hf9;
    localparam logic [7:0]  COUNTER_HIGH_ADDR = 8'hfa;
    localparam logic [7:0]  PWM_CONFIG_ADDR   = 8'hf7;
    localparam logic [2:0][7:0] CAP_LOW_ADDR  = {8'heb, 8'he9, 8'hfb};
    localparam logic [2:0][7:0] CAP_HIGH_ADDR = {8'hec, 8'hea, 8'hfc};
    localparam logic [2:0][7:0] MODE_ADDR     = {8'hdc, 8'hdb, 8'hda};
    localparam int          COMP_ENABLE_BIT = 6;
    localparam int          AUTO_RELOAD_SEL_BIT = 7;
    localparam logic [7:0]  BYTE_RESET      = 8'h00;
    localparam logic [15:0] WORD_RESET      = 16'h0000;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pgc_sfr_req_s;

    typedef struct packed {
        logic [7:0] rdata;
        logic       rvalid;
    } pgc_sfr_rsp_s;

endpackage

// file: rtl/pgc_channel.sv
// One capture/compare module: capture value, auto-reload value and mode.
module pgc_channel (
    // Clock and reset.
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    // Register access strobes from the decoder.
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_low_i,
    input  wire logic        wr_high_i,
    input  wire logic        wr_mode_i,
    input  wire logic        auto_reload_select_i,
    // Capture from the counting datapath.
    input  wire logic        capture_strobe_i,
    input  wire logic [15:0] counter_i,
    // Register contents.
    output logic      [15:0] capture_o,
    output logic      [15:0] reload_o,
    output logic      [7:0]  mode_o
);
    import pgc_pkg::*;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            capture_o <= WORD_RESET;
        end else if (wr_low_i && !auto_reload_select_i) begin
            capture_o[7:0] <= wdata_i;
        end else if (wr_high_i && !auto_reload_select_i) begin
            capture_o[15:8] <= wdata_i;
        end else if (capture_strobe_i) begin
            capture_o <= counter_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            reload_o <= WORD_RESET;
        end else if (wr_low_i && auto_reload_select_i) begin
            reload_o[7:0] <= wdata_i;
        end else if (wr_high_i && auto_reload_select_i) begin
            reload_o[15:8] <= wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mode_o <= BYTE_RESET;
        end else if (wr_mode_i) begin
            mode_o <= wdata_i;
        end else if (wr_low_i) begin
            mode_o[COMP_ENABLE_BIT] <= 1'b0;
        end else if (wr_high_i) begin
            mode_o[COMP_ENABLE_BIT] <= 1'b1;
        end
    end

endmodule

// file: tb/pgc_regs_test.sv
// Self-checking testbench of the counter array register file.
module pgc_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import pgc_pkg::*;

    logic                 ref_clk_i        = 1'b0;
    logic                 reset_i          = 1'b1;
    pgc_sfr_req_s         sfr_req_i        = '0;
    pgc_sfr_rsp_s         sfr_rsp_o;
    logic                 count_tick_i     = 1'b0;
    logic [2:0]           capture_strobe_i = 3'h0;
    logic [15:0]          counter_o;
    logic [2:0][15:0]     capture_value_o;
    logic [2:0][15:0]     auto_reload_o;
    logic [2:0][7:0]      module_mode_o;
    logic [2:0]           comparator_enable_o;
    logic                 auto_reload_select_o;
    int                   mismatches = 0;
    int                   checks     = 0;
    int                   cnt, snap, pwm, exp_rd, exp_vld;
    int                   cap[3], rel[3], mode[3];
    logic [7:0]           alist[$];

    always #20 ref_clk_i = ~ref_clk_i;

    pgc_regs pgc_regs_inst (
        .ref_clk_i            (ref_clk_i),
        .reset_i              (reset_i),
        .sfr_req_i            (sfr_req_i),
        .sfr_rsp_o            (sfr_rsp_o),
        .count_tick_i         (count_tick_i),
        .capture_strobe_i     (capture_strobe_i),
        .counter_o            (counter_o),
        .capture_value_o      (capture_value_o),
        .auto_reload_o        (auto_reload_o),
        .module_mode_o        (module_mode_o),
        .comparator_enable_o  (comparator_enable_o),
        .auto_reload_select_o (auto_reload_select_o)
    );

    task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic int rd_val(input int a);
        if (a == int'(COUNTER_LOW_ADDR)) return cnt & 255;
        if (a == int'(COUNTER_HIGH_ADDR)) return snap;
        if (a == int'(PWM_CONFIG_ADDR)) return pwm;
        for (int i = 0; i < NUM_CH; i++) begin
            if (a == int'(CAP_LOW_ADDR[i]))
                return (pwm[7] ? rel[i] : cap[i]) & 255;
            if (a == int'(CAP_HIGH_ADDR[i]))
                return ((pwm[7] ? rel[i] : cap[i]) >> 8) & 255;
            if (a == int'(MODE_ADDR[i])) return mode[i];
        end
        return 0;
    endfunction

    // Reference model, updated from the inputs sampled at each edge.
    always @(posedge ref_clk_i or posedge reset_i) begin : model
        int a, w;
        a = int'(sfr_req_i.addr);
        w = int'(sfr_req_i.wdata);
        if (reset_i) begin
            {cnt, snap, pwm, exp_rd, exp_vld} = '0;
            cap = '{0, 0, 0};
            rel = '{0, 0, 0};
            mode = '{0, 0, 0};
        end else begin
            exp_vld = int'(sfr_req_i.rd);
            exp_rd = sfr_req_i.rd ? rd_val(a) : 0;
            if (sfr_req_i.rd && a == int'(COUNTER_LOW_ADDR))
                snap = (cnt >> 8) & 255;
            for (int i = 0; i < NUM_CH; i++)
                if (capture_strobe_i[i] && !(sfr_req_i.wr && !pwm[7]
                    && (a == int'(CAP_LOW_ADDR[i])
                        || a == int'(CAP_HIGH_ADDR[i]))))
                    cap[i] = cnt;
            if (sfr_req_i.wr && a == int'(COUNTER_LOW_ADDR))
                cnt = (cnt & 'hff00) | w;
            else if (sfr_req_i.wr && a == int'(COUNTER_HIGH_ADDR))
                cnt = (cnt & 255) | (w << 8);
            else if (count_tick_i)
                cnt = (cnt + 1) & 'hffff;
            for (int i = 0; i < NUM_CH && sfr_req_i.wr; i++) begin
                if (a == int'(CAP_LOW_ADDR[i])) begin
                    if (pwm[7]) rel[i] = (rel[i] & 'hff00) | w;
                    else cap[i] = (cap[i] & 'hff00) | w;
                    mode[i] = mode[i] & 'hbf;
                end
                if (a == int'(CAP_HIGH_ADDR[i])) begin
                    if (pwm[7]) rel[i] = (rel[i] & 255) | (w << 8);
                    else cap[i] = (cap[i] & 255) | (w << 8);
                    mode[i] = mode[i] | 'h40;
                end
                if (a == int'(MODE_ADDR[i])) mode[i] = w;
            end
            if (sfr_req_i.wr && a == int'(PWM_CONFIG_ADDR)) pwm = w;
        end
    end

    // Outputs are compared with the model in the middle of every cycle.
    always @(negedge ref_clk_i) begin
        chk_out(counter_o, 16'(cnt));
        for (int i = 0; i < NUM_CH; i++) begin
            chk_out(capture_value_o[i], 16'(cap[i]));
            chk_out(auto_reload_o[i], 16'(rel[i]));
            chk_out({8'h00, module_mode_o[i]}, 16'(mode[i]));
            chk_out({15'h0, comparator_enable_o[i]},
                    16'((mode[i] >> 6) & 1));
        end
        chk_out({15'h0, auto_reload_select_o},
                16'((pwm >> 7) & 1));
        chk_rd({15'h0, sfr_rsp_o.rvalid}, 16'(exp_vld));
        chk_rd({8'h00, sfr_rsp_o.rdata}, 16'(exp_rd));
    end

    task automatic op(input bit w, input bit r, input logic [7:0] a,
                      input logic [7:0] d, input bit t,
                      input logic [2:0] s);
        @(posedge ref_clk_i);
        #1;
        sfr_req_i = '{addr: a, wdata: d, wr: w, rd: r};
        count_tick_i = t;
        capture_strobe_i = s;
    endtask

    task automatic close_out;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #(40 * 8000);
        mismatches++;
        close_out();
    end

    initial begin : main
        int k;
        void'($urandom(36));
        alist = '{COUNTER_LOW_ADDR, COUNTER_HIGH_ADDR, PWM_CONFIG_ADDR,
                  8'h00, 8'h55};
        for (int i = 0; i < NUM_CH; i++) begin
            alist.push_back(CAP_LOW_ADDR[i]);
            alist.push_back(CAP_HIGH_ADDR[i]);
            alist.push_back(MODE_ADDR[i]);
        end
        repeat (5) @(posedge ref_clk_i);
        #1 reset_i = 1'b0;
        // Low byte read on a carry edge, then high byte read back to back.
        op(1, 0, COUNTER_HIGH_ADDR, 8'h12, 0, 3'h0);
        op(1, 0, COUNTER_LOW_ADDR, 8'hff, 0, 3'h0);
        op(0, 1, COUNTER_LOW_ADDR, 8'h00, 1, 3'h0);
        op(0, 1, COUNTER_HIGH_ADDR, 8'h00, 1, 3'h0);
        for (int n = 0; n < 6000; n++) begin
            if (n == 3000) begin
                @(posedge ref_clk_i);
                #1 reset_i = 1'b1;
                repeat (2) @(posedge ref_clk_i);
                #1 reset_i = 1'b0;
            end
            k = $urandom % 3;
            op(k == 0, k == 1, alist[$urandom % alist.size()],
               8'($urandom), 1'($urandom),
               ($urandom % 4 != 0) ? 3'h0 : 3'($urandom));
        end
        op(0, 0, 8'h00, 8'h00, 0, 3'h0);
        repeat (2) @(posedge ref_clk_i);
        close_out();
    end
endmodule
